// file: rtl/cbp_pkg.sv
// What this block does
// - receive buffer id low byte ignores writes
// - transmit buffer id low byte readable, writable
// - receive buffer has eight read-only data bytes
// - transmit buffer has eight writable data bytes
// - payload registers exist only in modes 1, 2
// - receive length bit 6 shows remote request
// - receive length bits 7, 5, 4 read zero
// - length code 0 to 8 counts bytes directly
// - transmit length bit 6 sets sent remote bit
// - transmit length bits 7, 5, 4 unimplemented
// - per-buffer select bit: 1 transmit, 0 receive
// - extended frame makes low id byte meaningful
// - pending or active transmit locks buffer writes
package cbp_pkg;

  // ********************************************************
  // sizes and address map
  // ********************************************************
  localparam int unsigned CBP_NUM_BUF   = 6;   // programmable buffers
  localparam int unsigned CBP_NUM_BYTES = 8;   // data field bytes per buffer
  localparam logic [2:0]  CBP_CTRL_BLK  = 3'h6; // block of the control words
  localparam logic [3:0]  CBP_W_EXT_LOW = 4'h0; // word: extended id low byte
  localparam logic [3:0]  CBP_W_DATA0   = 4'h1; // word: data byte 0
  localparam logic [3:0]  CBP_W_DATA7   = 4'h8; // word: data byte 7
  localparam logic [3:0]  CBP_W_LENGTH  = 4'h9; // word: length code
  localparam logic [3:0]  CBP_W_SELECT  = 4'h0; // control word: direction select
  localparam logic [3:0]  CBP_W_MODE    = 4'h1; // control word: functional mode
  localparam logic [3:0]  CBP_W_LOCK    = 4'h2; // control word: write lock status

  // ********************************************************
  // field positions and reset values
  // ********************************************************
  localparam int unsigned CBP_LEN_REMOTE_BIT = 6;     // remote request in length reg
  localparam logic [1:0]  CBP_MODE_LEGACY    = 2'h0;  // payload registers absent
  localparam logic [1:0]  CBP_MODE_ENHANCED  = 2'h1;
  localparam logic [1:0]  CBP_MODE_FIFO      = 2'h2;
  localparam logic [1:0]  CBP_MODE_RESET     = 2'h0;
  localparam logic [5:0]  CBP_SELECT_RESET   = 6'h00; // all buffers receive
  localparam logic [7:0]  CBP_BYTE_RESET     = 8'h00;
  localparam logic [3:0]  CBP_CODE_RESET     = 4'h0;

  // ********************************************************
  // carriers
  // ********************************************************
  typedef struct packed {
    logic            extended;         // rx_extended_flag of the frame
    logic [7:0]      ext_id_low_bits;  // extended id bits 7..0
    logic [7:0][7:0] payload;          // data bytes, [0] sent first
    logic            remote;           // remote request bit
    logic [3:0]      byte_count_code;  // length code
  } cbp_frame_type;

  typedef struct packed {
    logic       hit_buf;   // word of a buffer
    logic       hit_ctrl;  // control word
    logic [2:0] buf_idx;   // buffer number
    logic [3:0] word;      // word inside the block
    logic [2:0] byte_idx;  // data byte number
  } cbp_dec_type;

  // address decode, shared by read and write paths
  function automatic cbp_dec_type cbp_decode(input logic [8:0] addr);
    cbp_dec_type d;
    d.buf_idx  = addr[8:6];
    d.word     = addr[5:2];
    d.byte_idx = 3'(addr[5:2] - CBP_W_DATA0);
    d.hit_buf  = (addr[8:6] < 3'(CBP_NUM_BUF)) && (addr[5:2] <= CBP_W_LENGTH);
    d.hit_ctrl = (addr[8:6] == CBP_CTRL_BLK) && (addr[5:2] <= CBP_W_LOCK);
    return d;
  endfunction

endpackage

// file: rtl/cbp_payload_regs.sv
`timescale 1ns/100ps
module cbp_payload_regs
  import cbp_pkg::*;
(
  // clock, reset, enable
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 clk_en,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // state of the buffer controls outside
  input  wire logic [5:0]           send_request,
  input  wire logic [5:0]           tx_busy,
  // received frame from the protocol engine
  input  wire logic                 rx_load,
  input  wire logic [2:0]           rx_load_buf,
  input  wire cbp_pkg::cbp_frame_type rx_frame,
  // transmit frame fetch by the protocol engine
  input  wire logic                 tx_fetch,
  input  wire logic [2:0]           tx_fetch_buf,
  output cbp_pkg::cbp_frame_type    tx_frame,
  output logic                      tx_frame_valid,
  // configuration seen by the rest of the module
  output logic      [5:0]           buffer_tx_select,
  output logic      [1:0]           op_mode
);
  import cbp_pkg::*;

  // ********************************************************
  // storage
  // ********************************************************
  logic [7:0] ext_low      [CBP_NUM_BUF];                 // id low byte
  logic [7:0] payload_byte [CBP_NUM_BUF][CBP_NUM_BYTES];  // data field
  logic       remote_flag  [CBP_NUM_BUF];                 // length bit 6
  logic [3:0] count_code   [CBP_NUM_BUF];                 // length bits 3..0

  // bus data phase bookkeeping
  logic       wr_pend;   // write data phase this cycle
  logic       rd_pend;   // read wait cycle this cycle
  logic [8:0] dp_addr;   // address of the data phase

  // ********************************************************
  // decode and qualifiers
  // ********************************************************
  wire logic        addr_take = hsel & htrans[1] & hready;  // nonseq or seq
  wire cbp_dec_type dec       = cbp_decode(dp_addr);        // data phase decode
  // payload registers exist only in the two enhanced modes
  wire logic        mode_ok   = (op_mode == CBP_MODE_ENHANCED) |
                                (op_mode == CBP_MODE_FIFO);
  // buffer with a pending request or busy sending: software may only look
  wire logic [5:0]  wr_lock   = send_request | tx_busy;
  wire logic        sw_write  = clk_en & wr_pend & dec.hit_buf & mode_ok;
  wire logic        rx_ok     = clk_en & rx_load & mode_ok &
                                (rx_load_buf < 3'(CBP_NUM_BUF));
  wire logic [5:0]  rx_hit;  // receive load per buffer
  wire logic [5:0]  wr_hit;  // accepted software write per buffer

  // ********************************************************
  // per-buffer payload registers
  // ********************************************************
  for (genvar b = 0; b < CBP_NUM_BUF; b++)
  begin : g_buf
    // a frame is only loaded into a buffer set for reception
    assign rx_hit[b] = rx_ok & (rx_load_buf == 3'(b)) & ~buffer_tx_select[b];
    // writes land only in transmit buffers that are not locked
    assign wr_hit[b] = sw_write & (dec.buf_idx == 3'(b)) &
                       buffer_tx_select[b] & ~wr_lock[b];

    // receive load updates every field in one edge, so a read never
    // sees half an old frame and half a new one
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        ext_low[b]     <= CBP_BYTE_RESET;
        remote_flag[b] <= 1'b0;
        count_code[b]  <= CBP_CODE_RESET;
        for (int m = 0; m < CBP_NUM_BYTES; m++)
          payload_byte[b][m] <= CBP_BYTE_RESET;
      end
      else if (rx_hit[b])
      begin
        // low id byte is meaningful only for extended frames
        ext_low[b]     <= rx_frame.extended ? rx_frame.ext_id_low_bits
                                            : CBP_BYTE_RESET;
        remote_flag[b] <= rx_frame.remote;
        count_code[b]  <= rx_frame.byte_count_code;
        for (int m = 0; m < CBP_NUM_BYTES; m++)
          payload_byte[b][m] <= rx_frame.payload[m];
      end
      else if (wr_hit[b])
      begin
        // id low byte, data bytes, length: one word each
        if (dec.word == CBP_W_EXT_LOW)
          ext_low[b] <= hwdata[7:0];
        else if (dec.word == CBP_W_LENGTH)
        begin
          // bits 7, 5, 4 have no storage; the code is kept as written
          remote_flag[b] <= hwdata[CBP_LEN_REMOTE_BIT];
          count_code[b]  <= hwdata[3:0];
        end
        else
          payload_byte[b][dec.byte_idx] <= hwdata[7:0];
      end
    end
  end

  // ********************************************************
  // read multiplexer
  // ********************************************************
  wire logic [2:0] rb       = dec.buf_idx;
  // reserved frame bits and bit 7 have no storage and read zero
  wire logic [7:0] len_byte = {1'b0, remote_flag[rb], 2'b00, count_code[rb]};
  wire logic [7:0] buf_byte =
    (dec.word == CBP_W_EXT_LOW) ? ext_low[rb] :
    (dec.word == CBP_W_LENGTH)  ? len_byte    :
                                  payload_byte[rb][dec.byte_idx];
  wire logic [7:0] ctrl_byte =
    (dec.word == CBP_W_SELECT) ? {2'b00, buffer_tx_select} :
    (dec.word == CBP_W_MODE)   ? {6'h00, op_mode} :
                                 {2'b00, wr_lock};
  // unmapped words and absent registers answer zero
  wire logic [31:0] rd_word =
    (dec.hit_buf && mode_ok) ? {24'h000000, buf_byte}  :
    dec.hit_ctrl             ? {24'h000000, ctrl_byte} : 32'h00000000;

  // ********************************************************
  // ahb-lite slave
  // ********************************************************
  // reads take one wait state so hrdata comes from a flop and a
  // read right after a write always sees the written value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      dp_addr   <= 9'h000;
    end
    else if (clk_en)
    begin
      if (rd_pend)
      begin
        // end of the wait cycle: present data
        hrdata    <= rd_word;
        hreadyout <= 1'b1;
        rd_pend   <= 1'b0;
      end
      else
      begin
        // address phase; size is not checked, every access is a word
        wr_pend <= addr_take & hwrite;
        rd_pend <= addr_take & ~hwrite;
        if (addr_take)
          dp_addr <= haddr[8:0];
        if (addr_take && !hwrite)
          hreadyout <= 1'b0;
      end
    end
  end

  // ********************************************************
  // control words: direction select and functional mode
  // ********************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      buffer_tx_select <= CBP_SELECT_RESET;
      op_mode          <= CBP_MODE_RESET;
    end
    else if (clk_en && wr_pend && dec.hit_ctrl)
    begin
      if (dec.word == CBP_W_SELECT)
        buffer_tx_select <= hwdata[5:0];
      else if (dec.word == CBP_W_MODE)
        op_mode <= hwdata[1:0];
    end
  end

  // ********************************************************
  // transmit fetch
  // ********************************************************
  // the engine asks for one buffer; answer comes one edge later.
  // the extended flag lives in the identifier registers outside,
  // so it is left clear here for the engine to merge
  wire logic fetch_ok = tx_fetch & mode_ok & (tx_fetch_buf < 3'(CBP_NUM_BUF)) &
                        buffer_tx_select[tx_fetch_buf];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_frame       <= '0;
      tx_frame_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      tx_frame_valid <= fetch_ok;
      if (fetch_ok)
      begin
        tx_frame.extended        <= 1'b0;
        tx_frame.ext_id_low_bits <= ext_low[tx_fetch_buf];
        tx_frame.remote          <= remote_flag[tx_fetch_buf];
        tx_frame.byte_count_code <= count_code[tx_fetch_buf];
        for (int m = 0; m < CBP_NUM_BYTES; m++)
          tx_frame.payload[m] <= payload_byte[tx_fetch_buf][m];
      end
    end
  end

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  for (genvar a = 0; a < CBP_NUM_BUF; a++)
  begin : g_chk
    AST_RX_ID_READONLY: assert property (
      (sw_write && dec.buf_idx == 3'(a) && !buffer_tx_select[a] && !rx_hit[a])
      |=> $stable(ext_low[a]))
      else $error("receive buffer id low byte changed by a write");
    AST_TX_ID_WRITE: assert property (
      (wr_hit[a] && dec.word == CBP_W_EXT_LOW) |=> ext_low[a] == $past(hwdata[7:0]))
      else $error("transmit id low byte did not take the write");
    AST_RX_LOAD_ALL: assert property (
      rx_hit[a] |=> (payload_byte[a][7] == $past(rx_frame.payload[7])) &&
                    (count_code[a] == $past(rx_frame.byte_count_code)) &&
                    (remote_flag[a] == $past(rx_frame.remote)))
      else $error("received frame not loaded in one edge");
    AST_RX_STD_ID: assert property (
      (rx_hit[a] && !rx_frame.extended) |=> ext_low[a] == 8'h00)
      else $error("standard frame left an id low byte");
    AST_TX_REMOTE: assert property (
      (wr_hit[a] && dec.word == CBP_W_LENGTH)
      |=> remote_flag[a] == $past(hwdata[CBP_LEN_REMOTE_BIT]))
      else $error("transmit remote bit not taken from bit 6");
    AST_LOCKED: assert property (
      (sw_write && dec.buf_idx == 3'(a) && buffer_tx_select[a] && wr_lock[a])
      |=> $stable(count_code[a]) && $stable(payload_byte[a][0]))
      else $error("locked transmit buffer accepted a write");
    // a data byte write lands in the addressed byte
    AST_TX_DATA_WRITE: assert property (
      (wr_hit[a] && dec.word >= CBP_W_DATA0 && dec.word <= CBP_W_DATA7)
      |=> payload_byte[a][$past(dec.byte_idx)] == $past(hwdata[7:0]))
      else $error("transmit data byte did not take the write");
    // the code is kept as written, reserved codes included
    AST_TX_CODE: assert property (
      (wr_hit[a] && dec.word == CBP_W_LENGTH) |=> count_code[a] == $past(hwdata[3:0]))
      else $error("transmit length code not taken from bits 3 to 0");
    // an extended frame keeps its low identifier byte
    AST_RX_EXT_ID: assert property (
      (rx_hit[a] && rx_frame.extended) |=> ext_low[a] == $past(rx_frame.ext_id_low_bits))
      else $error("extended frame lost its id low byte");
    // a frame offered to a transmit buffer must not land there
    AST_RX_INTO_TX: assert property (
      (clk_en && rx_load && rx_load_buf == 3'(a) && buffer_tx_select[a] && !wr_hit[a])
      |=> $stable(count_code[a]) && $stable(ext_low[a]))
      else $error("received frame overwrote a transmit buffer");
    // outside modes 1 and 2 the payload words take no writes
    AST_ABSENT_WRITE: assert property (
      (clk_en && wr_pend && dec.hit_buf && dec.buf_idx == 3'(a) && !mode_ok)
      |=> $stable(ext_low[a]) && $stable(payload_byte[a][0]))
      else $error("payload register written outside modes 1 and 2");
  end

  AST_READ_LENGTH: assert property (
    (clk_en && rd_pend && dec.hit_buf && mode_ok && dec.word == CBP_W_LENGTH)
    |=> hreadyout && (hrdata[31:7] == 25'h0) && (hrdata[5:4] == 2'b00) &&
        (hrdata[3:0] == $past(count_code[dec.buf_idx])))
    else $error("length register read wrong reserved or code bits");
  AST_ABSENT_MODE: assert property (
    (clk_en && rd_pend && dec.hit_buf && !mode_ok) |=> hrdata == 32'h0)
    else $error("payload register visible outside modes 1 and 2");
  AST_READ_WAIT: assert property (
    (clk_en && addr_take && !hwrite) |=> !hreadyout ##1 (hreadyout == $past(clk_en)))
    else $error("read wait state missing");
  AST_FETCH_RX: assert property (
    (clk_en && tx_fetch && !buffer_tx_select[tx_fetch_buf]) |=> !tx_frame_valid)
    else $error("receive buffer handed out for sending");
  // no valid pulse without an accepted fetch the edge before
  AST_FETCH_IDLE: assert property (
    (clk_en && !fetch_ok) |=> !tx_frame_valid)
    else $error("frame valid without an accepted fetch");

  // ********************************************************
  // read data, control words and fetch contents
  // ********************************************************
  // a data byte read answers with the byte stored at the wait cycle
  AST_READ_DATA: assert property (
    (clk_en && rd_pend && dec.hit_buf && mode_ok &&
     dec.word >= CBP_W_DATA0 && dec.word <= CBP_W_DATA7)
    |=> hrdata == {24'h000000, $past(payload_byte[dec.buf_idx][dec.byte_idx])})
    else $error("data byte read returned a wrong value");
  // the id low byte reads back whatever is stored, either direction
  AST_READ_ID: assert property (
    (clk_en && rd_pend && dec.hit_buf && mode_ok && dec.word == CBP_W_EXT_LOW)
    |=> hrdata == {24'h000000, $past(ext_low[dec.buf_idx])})
    else $error("id low byte read returned a wrong value");
  // bit 6 of the length word mirrors the stored remote flag
  AST_READ_REMOTE: assert property (
    (clk_en && rd_pend && dec.hit_buf && mode_ok && dec.word == CBP_W_LENGTH)
    |=> hrdata[CBP_LEN_REMOTE_BIT] == $past(remote_flag[dec.buf_idx]))
    else $error("length register bit 6 does not show the remote flag");
  // the lock word shows which buffers have a pending request or are busy sending
  AST_READ_LOCK: assert property (
    (clk_en && rd_pend && dec.hit_ctrl && dec.word == CBP_W_LOCK)
    |=> hrdata == {26'h0, $past(wr_lock)})
    else $error("lock status read does not match the lock levels");
  // writes are answered without a wait state
  AST_WRITE_NO_WAIT: assert property (
    (clk_en && addr_take && hwrite) |=> hreadyout)
    else $error("write stalled the bus");
  // the direction select takes the written bits
  AST_SELECT_WRITE: assert property (
    (clk_en && wr_pend && dec.hit_ctrl && dec.word == CBP_W_SELECT)
    |=> buffer_tx_select == $past(hwdata[5:0]))
    else $error("direction select did not take the write");
  // the mode word takes the written bits
  AST_MODE_WRITE: assert property (
    (clk_en && wr_pend && dec.hit_ctrl && dec.word == CBP_W_MODE)
    |=> op_mode == $past(hwdata[1:0]))
    else $error("functional mode did not take the write");
  // the fetched frame copies the buffer as it stood at the request
  AST_FETCH_COPY: assert property (
    (clk_en && fetch_ok)
    |=> tx_frame_valid && (tx_frame.remote == $past(remote_flag[tx_fetch_buf])) &&
        (tx_frame.byte_count_code == $past(count_code[tx_fetch_buf])))
    else $error("fetched frame does not match the buffer");

  COV_RX_LOAD:  cover property (rx_ok && rx_frame.extended ##1 clk_en && rd_pend);
  COV_TX_LEN:   cover property (wr_hit != 6'h00 && dec.word == CBP_W_LENGTH);
  COV_LOCKED:   cover property (sw_write && (wr_lock & buffer_tx_select) != 6'h00);
  COV_FETCH:    cover property (tx_frame_valid && tx_frame.remote);

endmodule

// file: verif/cbp_engine_model.sv
`timescale 1ns/100ps
module cbp_engine_model
  import cbp_pkg::*;
(
  // clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // buffer control state
  output logic [5:0]              send_request,
  output logic [5:0]              tx_busy,
  // receive side
  output logic                    rx_load,
  output logic [2:0]              rx_load_buf,
  output cbp_pkg::cbp_frame_type  rx_frame,
  // transmit side
  output logic                    tx_fetch,
  output logic [2:0]              tx_fetch_buf,
  input  wire cbp_pkg::cbp_frame_type tx_frame,
  input  wire logic               tx_frame_valid
);
  // ********************************************************
  // idle engine: nothing pending, no frame offered
  // ********************************************************
  initial
  begin
    send_request = 6'h00;
    tx_busy      = 6'h00;
    rx_load      = 1'b0;
    rx_load_buf  = 3'h0;
    rx_frame     = '0;
    tx_fetch     = 1'b0;
    tx_fetch_buf = 3'h0;
  end

  // hand a received frame over in one pulse, all fields together
  task automatic load(input logic [2:0] b, input cbp_frame_type f);
    @(posedge hclk);
    rx_load     <= 1'b1;
    rx_load_buf <= b;
    rx_frame    <= f;
    @(posedge hclk);
    rx_load     <= 1'b0;
    // released lines do not keep the old frame, so stale use shows up
    rx_frame    <= ~f;
    rx_load_buf <= ~b;
  endtask

  // fetch a transmit frame; valid is looked at in its one cycle
  task automatic fetch(input logic [2:0] b, output logic ok, output cbp_frame_type f);
    @(posedge hclk);
    tx_fetch     <= 1'b1;
    tx_fetch_buf <= b;
    @(posedge hclk);
    tx_fetch     <= 1'b0;
    tx_fetch_buf <= ~b;
    @(posedge hclk);
    ok = tx_frame_valid;
    f  = tx_frame;
  endtask

  // pending request and busy levels that lock a buffer
  task automatic set_lock(input logic [5:0] sr, input logic [5:0] bz);
    @(posedge hclk);
    send_request <= sr;
    tx_busy      <= bz;
  endtask
endmodule

// file: verif/can_buffer_payload_regs_test.sv
`timescale 1ns/100ps
module can_buffer_payload_regs_test;
  import cbp_pkg::*;
  // ********************************************************
  // signals and reference state
  // ********************************************************
  logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0]    htrans;
  logic [31:0]   haddr, hwdata, hrdata, rdat;
  logic [5:0]    send_request, tx_busy, buffer_tx_select;
  logic [1:0]    op_mode;
  logic          rx_load, tx_fetch, tx_frame_valid, ok;
  logic [2:0]    rx_load_buf, tx_fetch_buf;
  cbp_frame_type rx_frame, tx_frame, fr;
  int            mem [6][10];  // reference copy of every buffer word
  int            sel, mode, errors, check_count, cycles, b, w, d, m;

  always #50 hclk = ~hclk;

  cbp_payload_regs uut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .send_request(send_request), .tx_busy(tx_busy), .rx_load(rx_load),
    .rx_load_buf(rx_load_buf), .rx_frame(rx_frame), .tx_fetch(tx_fetch),
    .tx_fetch_buf(tx_fetch_buf), .tx_frame(tx_frame), .tx_frame_valid(tx_frame_valid),
    .buffer_tx_select(buffer_tx_select), .op_mode(op_mode));

  cbp_engine_model eng (.hclk(hclk), .hresetn(hresetn), .send_request(send_request),
    .tx_busy(tx_busy), .rx_load(rx_load), .rx_load_buf(rx_load_buf), .rx_frame(rx_frame),
    .tx_fetch(tx_fetch), .tx_fetch_buf(tx_fetch_buf), .tx_frame(tx_frame),
    .tx_frame_valid(tx_frame_valid));

  // ********************************************************
  // reference model and comparisons
  // ********************************************************
  function automatic logic [31:0] exp_rd(input int a);
    if (a == 'h180) return sel;
    if (a == 'h184) return mode;
    if (a == 'h188) return 32'(send_request | tx_busy);
    // payload words only exist in the two enhanced modes
    if (a / 64 < 6 && (a % 64) / 4 <= 9 && (mode == 1 || mode == 2)) return mem[a / 64][(a % 64) / 4];
    return 32'h0;
  endfunction

  function automatic cbp_frame_type exp_frame(input int n);
    cbp_frame_type f;
    f.extended        = 1'b0;
    f.ext_id_low_bits = 8'(mem[n][0]);
    for (int i = 0; i < 8; i++) f.payload[i] = 8'(mem[n][i + 1]);
    f.remote          = mem[n][9][6];
    f.byte_count_code = 4'(mem[n][9]);
    return f;
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_frame(input cbp_frame_type got, input cbp_frame_type exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t frame got %h expected %h", $time, got, exp);
    end
  endtask

  // one single ahb-lite transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] v);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic wr(input int a, input int v);
    bus(1'b1, 32'(a), 32'(v));
    if (a == 'h180) sel = v & 'h3f;
    else if (a == 'h184) mode = v & 3;
    else if (a / 64 < 6 && (a % 64) / 4 <= 9 && (mode == 1 || mode == 2) && sel[a / 64] &&
             !(send_request[a / 64] | tx_busy[a / 64]))
      mem[a / 64][(a % 64) / 4] = ((a % 64) / 4 == 9) ? v & 'h4f : v & 'hff;
  endtask

  task automatic rd(input int a);
    bus(1'b0, 32'(a), 32'h0);
    chk_word(rdat, exp_rd(a));
    chk_word(32'({hresp, op_mode, buffer_tx_select}), 32'({1'b0, 2'(mode), 6'(sel)}));
  endtask

  task automatic rd_all;
    for (int n = 0; n < 6; n++) for (int k = 0; k < 10; k++) rd(n * 64 + k * 4);
  endtask

  task report_and_stop;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // cut a hang short
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles > 30000)
    begin
      errors++;
      $display("[ERR] %0t run did not finish", $time);
      report_and_stop;
    end
  end

  // ********************************************************
  // main sequence
  // ********************************************************
  initial
  begin
    hclk = 0; hresetn = 0; hsel = 0; htrans = 0; haddr = 0; hwrite = 0; hwdata = 0;
    errors = 0; check_count = 0; cycles = 0; sel = 0; mode = 0;
    foreach (mem[i, j]) mem[i][j] = 0;
    d = $urandom(89109);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd('h180); rd('h184); rd('h188); rd('h24);
    wr('h180, 'h3f); wr('h4, 'h55); rd('h4);
    wr('h180, 'h2a); wr('h184, 1);
    // random fill; length codes stay within 0..8, upper bits random
    for (b = 0; b < 6; b++) for (w = 0; w < 10; w++)
      wr(b * 64 + w * 4, (w == 9) ? ($urandom & 'hf0) | ($urandom % 9) : $urandom);
    rd_all;
    for (b = 0; b < 6; b++)
    begin
      fr = cbp_frame_type'({$urandom, $urandom, $urandom});
      fr.byte_count_code = 4'($urandom % 9);
      fr.extended = b[1];
      eng.load(3'(b), fr);
      if (!sel[b])
      begin
        mem[b][0] = fr.extended ? fr.ext_id_low_bits : 0;
        for (m = 0; m < 8; m++) mem[b][m + 1] = fr.payload[m];
        mem[b][9] = {fr.remote, 2'b00, fr.byte_count_code};
      end
    end
    rd_all;
    for (b = 0; b < 6; b++)
    begin
      eng.fetch(3'(b), ok, fr);
      chk_word(32'(ok), 32'(sel[b]));
      if (sel[b]) chk_frame(fr, exp_frame(b));
    end
    eng.set_lock(6'h02, 6'h08);
    wr('h48, 'ha5); wr('hc0, 'h5a); rd('h48); rd('hc0); rd('h188);
    eng.set_lock(6'h00, 6'h00);
    wr('h48, 'ha5); rd('h48);
    wr('h184, 2); rd_all;
    wr('h184, 3); rd('h44); rd('h28); rd('h18c); rd('h1c0);
    report_and_stop;
  end
endmodule
